// File: hdl/tsm_regs.svh
`ifndef TSM_REGS_SVH
`define TSM_REGS_SVH

// Register indexes; byte address is four times the index
`define TSM_IDX_STATUS 3'h0
`define TSM_IDX_CFG    3'h1
`define TSM_IDX_TEMP   3'h2
`define TSM_IDX_ID     3'h3
`define TSM_IDX_CRIT   3'h4
`define TSM_IDX_HYST   3'h5
`define TSM_IDX_HIGH   3'h6
`define TSM_IDX_LOW    3'h7

`define TSM_STATUS_RST 8'h80
`define TSM_CFG_RST    8'h00
`define TSM_TEMP_RST   16'h0000
`define TSM_CRIT_RST   16'h4980
`define TSM_HYST_RST   8'h05
`define TSM_HIGH_RST   16'h2000
`define TSM_LOW_RST    16'h0500

`define TSM_OP_CONT 2'h0
`define TSM_OP_ONE  2'h1
`define TSM_OP_SPS  2'h2
`define TSM_OP_SHUT 2'h3

`define TSM_CLK_KHZ      50000
`define TSM_CONT_CONV_MS 240
`define TSM_SPS_CONV_MS  60
`define TSM_SPS_IDLE_MS  940
`define TSM_WAKE_MS      1
`define TSM_FAST_MS      6

`endif

// File: hdl/tsm_pkg.sv
package tsm_pkg;

  typedef struct packed {
    logic       res16;
    logic [1:0] op_mode;
    logic       cmp_mode;
    logic       lim_pol;
    logic       crit_pol;
    logic [1:0] fault_depth;
  } tsm_cfg_t;

  // Bit 0 critical, bit 1 upper, bit 2 lower
  typedef struct packed {
    logic low;
    logic high;
    logic crit;
  } tsm_flags_t;

  typedef enum logic [1:0] {
    TSM_WAKE,
    TSM_CONV,
    TSM_IDLE,
    TSM_SHUT
  } tsm_state_t;

endpackage

// File: hdl/tsm_seq.sv
`timescale 1ns/10ps
`default_nettype none
`include "tsm_regs.svh"

module tsm_seq #(
  parameter int unsigned CONV_US     = `TSM_CONT_CONV_MS * 1000,
  parameter int unsigned SPS_CONV_US = `TSM_SPS_CONV_MS * 1000,
  parameter int unsigned SPS_IDLE_US = `TSM_SPS_IDLE_MS * 1000,
  parameter int unsigned WAKE_US     = `TSM_WAKE_MS * 1000,
  parameter int unsigned FAST_US     = `TSM_FAST_MS * 1000
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       tick,
  input  wire logic [1:0] op_mode,
  input  wire logic       op_wr,
  output logic            conv_done,
  output logic            shut
);
  localparam int CW = 20;
  localparam logic [CW-1:0] IDLE_LD = CW'(SPS_IDLE_US - 1);
  localparam logic [CW-1:0] CONV_LD = CW'(CONV_US - 1);
  localparam logic [CW-1:0] WAKE_LD = CW'(WAKE_US - 1);

  tsm_pkg::tsm_state_t state_r;
  tsm_pkg::tsm_state_t state_nxt;
  logic [CW-1:0]       cnt_r;
  logic [CW-1:0]       cnt_nxt;
  logic                expire;

  assign expire    = tick && (cnt_r == '0);
  assign conv_done = expire && (state_r == tsm_pkg::TSM_CONV);
  assign shut      = (state_r == tsm_pkg::TSM_SHUT);

  always_comb begin
    state_nxt = state_r;
    if (op_wr) begin
      if (op_mode == `TSM_OP_SHUT) begin
        state_nxt = tsm_pkg::TSM_SHUT;
      end else if (state_r == tsm_pkg::TSM_SHUT) begin
        state_nxt = tsm_pkg::TSM_WAKE;
      end else begin
        state_nxt = tsm_pkg::TSM_CONV;
      end
    end else if (expire) begin
      unique case (state_r)
        tsm_pkg::TSM_WAKE: state_nxt = tsm_pkg::TSM_CONV;
        tsm_pkg::TSM_CONV: begin
          if (op_mode == `TSM_OP_SPS) begin
            state_nxt = tsm_pkg::TSM_IDLE;
          end else if (op_mode == `TSM_OP_CONT) begin
            state_nxt = tsm_pkg::TSM_CONV;
          end else begin
            state_nxt = tsm_pkg::TSM_SHUT;
          end
        end
        tsm_pkg::TSM_IDLE: state_nxt = tsm_pkg::TSM_CONV;
        tsm_pkg::TSM_SHUT: state_nxt = tsm_pkg::TSM_SHUT;
      endcase
    end
  end

  // Durations are counted in microsecond ticks
  always_comb begin
    cnt_nxt = cnt_r;
    if (op_wr || expire) begin
      unique case (state_nxt)
        tsm_pkg::TSM_WAKE: cnt_nxt = WAKE_LD;
        tsm_pkg::TSM_CONV: cnt_nxt = (op_mode == `TSM_OP_SPS) ?
                                     CW'(SPS_CONV_US - 1) : CONV_LD;
        tsm_pkg::TSM_IDLE: cnt_nxt = IDLE_LD;
        tsm_pkg::TSM_SHUT: cnt_nxt = '0;
      endcase
    end else if (tick) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // First conversion after reset is the short fast one
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_r <= tsm_pkg::TSM_CONV;
      cnt_r   <= CW'(FAST_US - 1);
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sps_idle_a: assert property (
    conv_done && op_mode == `TSM_OP_SPS && !op_wr
    |=> state_r == tsm_pkg::TSM_IDLE && cnt_r == IDLE_LD)
    else $error("idle phase not loaded after conversion");
  shut_enter_a: assert property (
    op_wr && op_mode == `TSM_OP_SHUT |=> shut)
    else $error("shutdown not entered");
  wake_len_a: assert property (
    shut && op_wr && op_mode == `TSM_OP_CONT
    |=> state_r == tsm_pkg::TSM_WAKE && cnt_r == WAKE_LD)
    else $error("wake-up not started from shutdown");
  one_shot_a: assert property (
    conv_done && op_mode == `TSM_OP_ONE && !op_wr |=> shut)
    else $error("one-shot did not return to shutdown");
  cont_next_a: assert property (
    conv_done && op_mode == `TSM_OP_CONT && !op_wr
    |=> state_r == tsm_pkg::TSM_CONV && cnt_r == CONV_LD)
    else $error("continuous conversion did not restart");

endmodule
`default_nettype wire

// File: hdl/tsm_core.sv
// Our own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "tsm_regs.svh"

module tsm_core #(
  parameter logic [7:0]  ID_CODE     = 8'h5A, // Arbitrary value
  parameter int unsigned CONV_US     = `TSM_CONT_CONV_MS * 1000,
  parameter int unsigned SPS_CONV_US = `TSM_SPS_CONV_MS * 1000,
  parameter int unsigned SPS_IDLE_US = `TSM_SPS_IDLE_MS * 1000,
  parameter int unsigned WAKE_US     = `TSM_WAKE_MS * 1000,
  parameter int unsigned FAST_US     = `TSM_FAST_MS * 1000
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [15:0] adc_code,
  output logic             conv_busy,
  output logic             critical_alarm_pin_o,
  output logic             critical_alarm_pin_oe_n,
  output logic             limit_alarm_pin_o,
  output logic             limit_alarm_pin_oe_n
);
  localparam int         TICK_DIV = `TSM_CLK_KHZ / 1000;
  localparam int         TW       = 6;
  localparam logic [7:0] ST_RST   = `TSM_STATUS_RST;

  // ****************************************
  // Microsecond tick
  // ****************************************
  logic [TW-1:0] div_r;
  logic          tick;

  assign tick = (div_r == TW'(TICK_DIV - 1));

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      div_r <= '0;
    end else if (tick) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  // ****************************************
  // Modulator word capture
  // ****************************************
  // The word counts only once two late stages agree, so a word
  // caught mid-change is never stored as a result.
  logic [15:0] code_s1_r;
  logic [15:0] code_s2_r;
  logic [15:0] code_s3_r;
  logic [15:0] code_r;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      code_s1_r <= 16'h0000;
      code_s2_r <= 16'h0000;
      code_s3_r <= 16'h0000;
    end else begin
      code_s1_r <= adc_code;
      code_s2_r <= code_s1_r;
      code_s3_r <= code_s2_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      code_r <= `TSM_TEMP_RST;
    end else if (code_s2_r == code_s3_r) begin
      code_r <= code_s3_r;
    end
  end

  // ****************************************
  // Avalon-MM slave
  // ****************************************
  logic       ack_r;
  logic       fire_rd;
  logic       fire_wr;
  logic [2:0] idx;

  assign idx             = avs_address[4:2];
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign fire_rd         = avs_read && ack_r;
  assign fire_wr         = avs_write && !avs_read && ack_r;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read || avs_write) && !ack_r;
    end
  end

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
    merge16 = {be[1] ? wd[15:8] : old[15:8],
               be[0] ? wd[7:0]  : old[7:0]};
  endfunction

  // ****************************************
  // Configuration and limit registers
  // ****************************************
  tsm_pkg::tsm_cfg_t cfg_r;
  logic [15:0]       crit_r;
  logic [7:0]        hyst_r;
  logic [15:0]       high_r;
  logic [15:0]       low_r;
  logic              op_wr;

  assign op_wr = fire_wr && (idx == `TSM_IDX_CFG) && avs_byteenable[0];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfg_r  <= `TSM_CFG_RST;
      crit_r <= `TSM_CRIT_RST;
      hyst_r <= `TSM_HYST_RST;
      high_r <= `TSM_HIGH_RST;
      low_r  <= `TSM_LOW_RST;
    end else if (fire_wr) begin
      if (op_wr) begin
        cfg_r <= avs_writedata[7:0];
      end
      if (idx == `TSM_IDX_CRIT) begin
        crit_r <= merge16(crit_r, avs_writedata, avs_byteenable);
      end
      if (idx == `TSM_IDX_HYST && avs_byteenable[0]) begin
        hyst_r <= avs_writedata[7:0];
      end
      if (idx == `TSM_IDX_HIGH) begin
        high_r <= merge16(high_r, avs_writedata, avs_byteenable);
      end
      if (idx == `TSM_IDX_LOW) begin
        low_r <= merge16(low_r, avs_writedata, avs_byteenable);
      end
    end
  end

  // ****************************************
  // Conversion sequencing
  // ****************************************
  logic       conv_done;
  logic       shut;
  logic [1:0] seq_mode;

  // A mode write steers the sequencer in its own cycle; later
  // decisions follow the stored mode, not stray bus data
  assign seq_mode = op_wr ? avs_writedata[6:5] : cfg_r.op_mode;

  tsm_seq #(
    .CONV_US     (CONV_US),
    .SPS_CONV_US (SPS_CONV_US),
    .SPS_IDLE_US (SPS_IDLE_US),
    .WAKE_US     (WAKE_US),
    .FAST_US     (FAST_US)
  ) u_seq (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .tick      (tick),
    .op_mode   (seq_mode),
    .op_wr     (op_wr),
    .conv_done (conv_done),
    .shut      (shut)
  );

  assign conv_busy = !shut;

  // ****************************************
  // Limit comparison
  // ****************************************
  // One comparator set serves both a fresh result and the stored
  // value, which a mode write re-examines.
  logic [15:0]        temp_r;
  logic [15:0]        mask;
  logic [15:0]        src;
  logic signed [16:0] tv;
  logic signed [16:0] crit_m;
  logic signed [16:0] high_m;
  logic signed [16:0] low_m;
  logic signed [16:0] hy;
  tsm_pkg::tsm_flags_t over;
  logic               fault;
  logic               crit_ok;
  logic               lim_ok;

  assign mask   = cfg_r.res16 ? 16'hFFFF : 16'hFFF8;
  assign src    = (conv_done ? code_r : temp_r) & mask;
  assign tv     = $signed({src[15], src});
  assign crit_m = $signed({crit_r[15], crit_r & mask});
  assign high_m = $signed({high_r[15], high_r & mask});
  assign low_m  = $signed({low_r[15], low_r & mask});
  assign hy     = $signed({6'h00, hyst_r[3:0], 7'h00});

  assign over.crit = tv > crit_m;
  assign over.high = tv > high_m;
  assign over.low  = tv < low_m;
  assign fault     = |over;
  assign crit_ok   = tv < (crit_m - hy);
  assign lim_ok    = (tv < (high_m - hy)) && (tv > (low_m + hy));

  // ****************************************
  // Result register
  // ****************************************
  // Nothing converts in shutdown, so the last result stays put.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      temp_r <= `TSM_TEMP_RST;
    end else if (conv_done) begin
      if (cfg_r.res16) begin
        temp_r <= code_r;
      end else begin
        temp_r <= {code_r[15:3], over};
      end
    end
  end

  // ****************************************
  // Fault queue
  // ****************************************
  logic [1:0] fq_r;
  logic       qual;

  assign qual = fault && (fq_r >= cfg_r.fault_depth);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fq_r <= 2'h0;
    end else if (conv_done) begin
      if (!fault) begin
        fq_r <= 2'h0;
      end else if (fq_r != 2'h3) begin
        fq_r <= fq_r + 1'b1;
      end
    end
  end

  // ****************************************
  // Alarm pins
  // ****************************************
  logic crit_act_r;
  logic lim_act_r;
  logic crit_set;
  logic lim_set;
  logic crit_clr;
  logic lim_clr;

  assign crit_set = conv_done && qual && over.crit;
  assign lim_set  = conv_done && qual && (over.high || over.low);

  // A new alarm wins over a clear in the same cycle
  always_comb begin
    if (!cfg_r.cmp_mode) begin
      crit_clr = fire_rd;
      lim_clr  = fire_rd;
    end else begin
      crit_clr = (conv_done || op_wr) && crit_ok;
      lim_clr  = (conv_done || op_wr) && lim_ok;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      crit_act_r <= 1'b0;
      lim_act_r  <= 1'b0;
    end else begin
      crit_act_r <= crit_set || (crit_act_r && !crit_clr);
      lim_act_r  <= lim_set || (lim_act_r && !lim_clr);
    end
  end

  // Open drain: the pin is pulled low when the output is enabled
  logic crit_drv_r;
  logic lim_drv_r;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      crit_drv_r <= 1'b0;
      lim_drv_r  <= 1'b0;
    end else begin
      crit_drv_r <= crit_act_r ^ cfg_r.crit_pol;
      lim_drv_r  <= lim_act_r ^ cfg_r.lim_pol;
    end
  end

  assign critical_alarm_pin_o    = 1'b0;
  assign critical_alarm_pin_oe_n = !crit_drv_r;
  assign limit_alarm_pin_o       = 1'b0;
  assign limit_alarm_pin_oe_n    = !lim_drv_r;

  // ****************************************
  // Status flags
  // ****************************************
  tsm_pkg::tsm_flags_t flag_r;
  logic                rdy_n_r;
  logic                st_rd;
  logic                op_rearm;

  assign st_rd    = fire_rd && (idx == `TSM_IDX_STATUS);
  assign op_rearm = op_wr && (cfg_r.op_mode == `TSM_OP_ONE ||
                              cfg_r.op_mode == `TSM_OP_SPS);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      flag_r <= '0;
    end else begin
      flag_r.crit <= (conv_done && over.crit) ||
                     (flag_r.crit && !st_rd && !(conv_done && crit_ok));
      flag_r.high <= (conv_done && over.high) ||
                     (flag_r.high && !st_rd &&
                      !(conv_done && tv < (high_m - hy)));
      flag_r.low  <= (conv_done && over.low) ||
                     (flag_r.low && !st_rd &&
                      !(conv_done && tv > (low_m + hy)));
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdy_n_r <= ST_RST[7];
    end else if (conv_done) begin
      rdy_n_r <= 1'b0;
    end else if ((fire_rd && idx == `TSM_IDX_TEMP) || op_rearm) begin
      rdy_n_r <= 1'b1;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  logic [31:0] rdata_r;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (avs_read && !ack_r) begin
      unique case (idx)
        `TSM_IDX_STATUS: rdata_r <= {24'h0, rdy_n_r, flag_r, 4'h0};
        `TSM_IDX_CFG:    rdata_r <= {24'h0, cfg_r};
        `TSM_IDX_TEMP:   rdata_r <= {16'h0, temp_r};
        `TSM_IDX_ID:     rdata_r <= {24'h0, ID_CODE};
        `TSM_IDX_CRIT:   rdata_r <= {16'h0, crit_r};
        `TSM_IDX_HYST:   rdata_r <= {24'h0, hyst_r};
        `TSM_IDX_HIGH:   rdata_r <= {16'h0, high_r};
        `TSM_IDX_LOW:    rdata_r <= {16'h0, low_r};
      endcase
    end
  end

  assign avs_readdata = rdata_r;

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  bus_answer_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held longer than one cycle");
  int_read_clr_a: assert property (
    fire_rd && !cfg_r.cmp_mode && !conv_done
    |=> !crit_act_r && !lim_act_r ##1 crit_drv_r == cfg_r.crit_pol)
    else $error("read did not clear alarms in interrupt mode");
  lim_mode_clr_a: assert property (
    op_wr && cfg_r.cmp_mode && lim_ok && !conv_done |=> !lim_act_r)
    else $error("mode write did not clear limit alarm");
  crit_mode_clr_a: assert property (
    op_wr && cfg_r.cmp_mode && crit_ok && !conv_done |=> !crit_act_r)
    else $error("mode write did not clear critical alarm");
  shut_hold_a: assert property (
    shut |=> $stable(temp_r))
    else $error("result changed during shutdown");
  fault_depth_a: assert property (
    $rose(crit_act_r) |-> $past(fq_r) >= $past(cfg_r.fault_depth))
    else $error("alarm raised before fault queue filled");
  fault_reset_a: assert property (
    conv_done && !fault |=> fq_r == 2'h0)
    else $error("fault count not reset by clean result");
  flag_bits_a: assert property (
    conv_done && !cfg_r.res16 && !op_wr
    |=> temp_r[2:0] == $past(over) && temp_r[15:3] == $past(code_r[15:3]))
    else $error("13-bit result or flags wrong");
  full_res_a: assert property (
    conv_done && cfg_r.res16 && !op_wr |=> temp_r == $past(code_r))
    else $error("16-bit result not stored whole");

  crit_alarm_c: cover property ($rose(crit_act_r));
  one_shot_c: cover property (
    cfg_r.op_mode == `TSM_OP_ONE && conv_done ##1 shut);
  int_clear_c: cover property (
    lim_act_r && fire_rd && !cfg_r.cmp_mode ##1 !lim_act_r);

endmodule
`default_nettype wire

// File: verification/tsm_adc_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Analog front end stand-in
// ****************************************
// Changes the word only at a clock edge, so the core never captures a
// half-updated code; the core's own capture handles the crossing.
module tsm_adc_model (
  input  wire logic        mclk,
  input  wire logic [15:0] temp_word,
  output logic      [15:0] adc_code
);
  always_ff @(posedge mclk) begin
    adc_code <= temp_word;
  end
endmodule
`default_nettype wire

// File: verification/temp_sensor_mode_alarm_core_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "tsm_regs.svh"

module temp_sensor_mode_alarm_core_tb;
  localparam logic [7:0] ID = 8'h3C; // Arbitrary value
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic [3:0]  avs_byteenable = 4'h0;
  logic        crit_o;
  logic        lim_o;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        conv_busy;
  logic        crit_oe_n;
  logic        lim_oe_n;
  logic [15:0] temp_word = 16'h0C80;
  logic [15:0] adc_code;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [31:0] seed = 32'hC346;
  logic [31:0] d;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          cyc = 0;

  initial begin
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;

  tsm_adc_model adc_u (.mclk(mclk), .temp_word(temp_word),
                       .adc_code(adc_code));
  tsm_core #(.ID_CODE(ID), .CONV_US(30), .SPS_CONV_US(5), .SPS_IDLE_US(15),
             .WAKE_US(2), .FAST_US(3)) dut_u (
    .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .adc_code(adc_code),
    .conv_busy(conv_busy), .critical_alarm_pin_o(crit_o),
    .critical_alarm_pin_oe_n(crit_oe_n), .limit_alarm_pin_o(lim_o),
    .limit_alarm_pin_oe_n(lim_oe_n));

  // ****************************************
  // Bus and compare helpers
  // ****************************************
  function automatic logic [31:0] xrand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input string name, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // The request stands until waitrequest is sampled low at a rising edge
  task automatic rd(input logic [2:0] idx, input logic [31:0] exp, msk);
    exp_q.push_back(exp);
    msk_q.push_back(msk);
    @(posedge mclk);
    avs_read    <= 1'b1;
    avs_address <= {idx, 2'b00};
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  task automatic wr_at(input logic [2:0] idx, input logic [31:0] v,
                       input logic [3:0] be);
    @(posedge mclk);
    avs_write      <= 1'b1;
    avs_address    <= {idx, 2'b00};
    avs_writedata  <= v;
    avs_byteenable <= be;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] v);
    wr_at(`TSM_IDX_CFG, v, 4'hF);
  endtask

  always @(negedge mclk) begin : mon
    logic [31:0] e;
    logic [31:0] m;
    if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      if (m != 32'h0) check("readdata", avs_readdata & m, e & m);
    end
  end

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask

  // Polls the ready flag; the caller reads the value to re-arm it
  task automatic wait_rdy(output int t);
    int n;
    n = 0;
    do begin
      rd(`TSM_IDX_STATUS, 32'h0, 32'h0);
      n++;
    end while (d[7] !== 1'b0 && n < 900);
    t = cyc;
    check("ready", {31'h0, d[7]}, 32'h0);
  endtask

  task automatic wait_pin(input logic crit, input logic lvl);
    int n;
    n = 0;
    while ((crit ? crit_oe_n : lim_oe_n) !== lvl && n < 2500) begin
      @(negedge mclk);
      n++;
    end
  endtask

  task automatic gap(input logic [31:0] cfg, input int per);
    int t0;
    int t1;
    wr(cfg);
    wait_rdy(t0);
    rd(`TSM_IDX_TEMP, 32'h1000, 32'hFFFF);
    wait_rdy(t1);
    rd(`TSM_IDX_TEMP, 32'h1000, 32'hFFFF);
    check("period", 32'(t1 - t0 > per - 40 && t1 - t0 < per + 40), 1);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge mclk);
    error_cnt++;
    print_verdict();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin : main
    logic [31:0] rst_tbl [8];
    logic [15:0] q_tbl [6];
    logic [5:0]  q_exp;
    logic [15:0] v;
    int          t;
    rst_tbl = '{32'h80, 32'h00, 32'h0000, 32'(ID), 32'h4980, 32'h05,
                32'h2000, 32'h0500};
    q_tbl = '{16'h2800, 16'h2800, 16'h0C80, 16'h2800, 16'h2800, 16'h2800};
    q_exp = 6'b011111;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) rd(3'(i), rst_tbl[i], 32'hFFFF);
    wr_at(`TSM_IDX_CFG, 32'h60, 4'hE);
    rd(`TSM_IDX_CFG, 32'h00, 32'hFF);
    check("lane_busy", 32'(conv_busy), 1);
    $display("test reset values done");

    wait_rdy(t);
    rd(`TSM_IDX_TEMP, 32'h0C80, 32'hFFFF);
    check("nine_bit", 32'(d[15:7]), 32'd25);
    v = 16'h0C80 | 16'(xrand() & 32'h7F);
    temp_word <= v;
    wr(32'h80);
    wait_rdy(t);
    rd(`TSM_IDX_TEMP, {16'h0, v}, 32'hFFFF);
    $display("test data format done");

    temp_word <= 16'h2800;
    wr(32'h00);
    wait_pin(1'b0, 1'b0);
    check("lim_on", 32'(lim_oe_n), 0);
    check("crit_off", 32'(crit_oe_n), 1);
    check("pin_out", {30'h0, crit_o, lim_o}, 0);
    rd(`TSM_IDX_ID, 32'(ID), 32'hFF);
    settle(3);
    check("lim_read_clr", 32'(lim_oe_n), 1);
    wr(32'h0C);
    settle(3);
    check("pol_high", {30'h0, crit_oe_n, lim_oe_n}, 0);
    wr(32'h00);
    settle(3);
    $display("test interrupt mode done");

    temp_word <= 16'h4B00;
    wr(32'h10);
    wait_pin(1'b1, 1'b0);
    rd(`TSM_IDX_TEMP, 32'h4B03, 32'hFFFF);
    settle(3);
    check("crit_kept", 32'(crit_oe_n), 0);
    check("lim_kept", 32'(lim_oe_n), 0);
    // Inside the hysteresis band no conversion clears; only a mode
    // write after the band is narrowed may do it
    temp_word <= 16'h4800;
    wait_rdy(t);
    wr_at(`TSM_IDX_HYST, 32'h0, 4'h1);
    wr(32'h10);
    settle(3);
    check("crit_clr", 32'(crit_oe_n), 1);
    check("lim_hold", 32'(lim_oe_n), 0);
    temp_word <= 16'h1F00;
    wr_at(`TSM_IDX_HYST, 32'h5, 4'h1);
    rd(`TSM_IDX_TEMP, 32'h0, 32'h0);
    wait_rdy(t);
    check("lim_band", 32'(lim_oe_n), 0);
    wr_at(`TSM_IDX_HYST, 32'h0, 4'h1);
    wr(32'h10);
    settle(3);
    check("lim_clr", 32'(lim_oe_n), 1);
    $display("test comparator mode done");

    temp_word <= q_tbl[0];
    rd(`TSM_IDX_TEMP, 32'h0, 32'h0);
    wr(32'h12);
    for (int i = 0; i < 6; i++) begin
      wait_rdy(t);
      rd(`TSM_IDX_TEMP, 32'h0, 32'h0);
      settle(2);
      check("queue", 32'(lim_oe_n), 32'(q_exp[i]));
      if (i < 5) temp_word <= q_tbl[i + 1];
    end
    $display("test fault queue done");

    temp_word <= 16'h1000;
    wr(32'h20);
    wait_rdy(t);
    rd(`TSM_IDX_TEMP, 32'h1000, 32'hFFFF);
    settle(5);
    check("oneshot_stop", 32'(conv_busy), 0);
    wr(32'h20);
    settle(1);
    check("oneshot_again", 32'(conv_busy), 1);
    wait_rdy(t);
    rd(`TSM_IDX_TEMP, 32'h1000, 32'hFFFF);
    gap(32'h40, 1000);
    gap(32'h00, 1500);
    $display("test conversion modes done");

    wr(32'h60);
    settle(2);
    check("shut", 32'(conv_busy), 0);
    temp_word <= 16'h1800;
    repeat (2000) @(posedge mclk);
    rd(`TSM_IDX_TEMP, 32'h1000, 32'hFFFF);
    wr(32'h00);
    settle(1);
    check("wake", 32'(conv_busy), 1);
    wait_rdy(t);
    rd(`TSM_IDX_TEMP, 32'h1800, 32'hFFFF);
    $display("test shutdown done");
    print_verdict();
  end
endmodule
`default_nettype wire
